// *** core/amp_state_fault_manager.sv ***
// What this block does
// - Fault pin low on automatic Hi-Z/standby
// - Fault cause readable, except supply POR drop
// - Clip/warning pin shows warning, clip, or both
// - Tweeter detect also asserts clip/warning pin
// - Mute pin mutes all channels, ramped release
// - Standby pin clears registers, floats host link
// - Channel phase offset 45 or 180 degrees
// - Four states: standby, Hi-Z, mute, play
// - Global faults map to standby/Hi-Z, latch or not
// - Channel events: diag latched, clip, foldback
// - Current limit starts timer; overcurrent/DC latch Hi-Z
// - Ramps and register updates follow mute voltage
// - Frequency field decode, 11 invalid
// - Clip/warning selection field decode
`include "amp_ctrl_map.svh"
`default_nettype none
module amp_state_fault_manager #(
  parameter int NCH       = 2,
  parameter int OC_CYCLES = `OC_CYCLES
) (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        standby_n_in,
  input  wire logic                        mute_n_in,
  input  wire logic                        por_drop,
  input  wire logic                        undervolt,
  input  wire logic                        overvolt,
  input  wire logic                        overtemp_warning,
  input  wire logic                        overtemp_shutdown,
  input  wire logic [NCH-1:0]              clip_det,
  input  wire logic [NCH-1:0]              cycle_current_limit,
  input  wire logic [NCH-1:0]              dc_det,
  input  wire logic [NCH-1:0]              foldback,
  input  wire logic [NCH-1:0]              diag_fault,
  input  wire logic                        tweeter_diag_run,
  input  wire logic                        tweeter_found,
  input  wire logic                        mute_ramp_done,
  input  wire logic                        host_wr,
  input  wire logic [1:0]                  host_fsw,
  input  wire logic [1:0]                  host_cwsel,
  input  wire logic                        host_phase_wide,
  input  wire logic                        host_foldback_rep,
  input  wire logic [NCH-1:0]              host_play,
  input  wire logic [NCH-1:0]              host_unhiz,
  input  wire logic                        host_clear,
  output logic                             fault_n_out,
  output logic                             fault_n_oe,
  output logic                             clip_warn_n_out,
  output logic                             host_link_en,
  output logic [1:0]                       ch_state [NCH],
  output logic [NCH-1:0]                   hard_mute,
  output logic [NCH-1:0]                   ramp_mute,
  output amp_ctrl_pkg::freq_t              fsw_sel,
  output logic [7:0]                       phase_deg,
  output logic                             fsw_invalid,
  output logic [7:0]                       fault_status,
  output logic [NCH-1:0]                   ch_oc_status,
  output logic [NCH-1:0]                   ch_dc_status,
  output logic [NCH-1:0]                   ch_diag_status,
  output logic [NCH-1:0]                   ch_foldback_status
);
  localparam int CW = $clog2(OC_CYCLES + 1);

  // Synchronised pins: standby, mute
  logic [1:0] pins_s;
  pin_sync3 #(.W(2), .RST(2'h3)) u_sync (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .pin_in    ({standby_n_in, mute_n_in}),
    .level_out (pins_s)
  );
  logic stby_s;  // Standby asserted
  logic mute_s;  // Mute asserted
  assign stby_s = ~pins_s[1];
  assign mute_s = ~pins_s[0];

  // All block state
  typedef struct packed {
    logic [1:0]              fsw;
    logic [1:0]              cwsel;
    logic                    wide;
    logic                    fold_rep;
    logic [NCH-1:0]          play;
    logic [NCH-1:0]          unhiz;
    logic                    uv_l;
    logic                    ov_l;
    logic                    ots_l;
    logic                    por_l;
    logic [NCH-1:0]          oc_l;
    logic [NCH-1:0]          dc_l;
    logic [NCH-1:0]          diag_l;
    logic [NCH-1:0][CW-1:0]  oc_cnt;
    logic [NCH-1:0][1:0]     st;
    logic                    fault_n;
    logic                    clip_n;
  } core_st_t;
  core_st_t s_r;
  core_st_t s_nxt;

  // Decode frequency field
  function automatic amp_ctrl_pkg::freq_t dec_fsw(input logic [1:0] f);
    if (f == `FSW_500K) begin
      dec_fsw = amp_ctrl_pkg::FREQ_500K;
    end else if (f == `FSW_357K) begin
      dec_fsw = amp_ctrl_pkg::FREQ_357K;
    end else if (f == `FSW_INVALID) begin
      dec_fsw = amp_ctrl_pkg::FREQ_BAD;
    end else begin
      dec_fsw = amp_ctrl_pkg::FREQ_417K;
    end
  endfunction : dec_fsw

  // Next-state logic
  always_comb begin
    logic glob_stby;
    logic glob_hiz;
    logic cw_any;
    glob_stby = 1'b0;  // Defaults before any branch
    glob_hiz  = 1'b0;
    cw_any    = 1'b0;
    s_nxt = s_r;
    // Host writes only take effect while ramp is settled
    if (host_wr && mute_ramp_done) begin
      s_nxt.fsw      = host_fsw;
      s_nxt.cwsel    = host_cwsel;
      s_nxt.wide     = host_phase_wide;
      s_nxt.fold_rep = host_foldback_rep;
      s_nxt.play     = host_play;
      s_nxt.unhiz    = host_unhiz;
    end
    // Host clear of latched faults; a present event wins
    if (host_clear) begin
      s_nxt.uv_l   = 1'b0;
      s_nxt.ov_l   = 1'b0;
      s_nxt.ots_l  = 1'b0;
      s_nxt.oc_l   = '0;
      s_nxt.dc_l   = '0;
      s_nxt.diag_l = '0;
    end
    // Global fault capture
    s_nxt.por_l = por_drop;
    if (undervolt) s_nxt.uv_l = 1'b1;
    if (overvolt) s_nxt.ov_l = 1'b1;
    if (overtemp_shutdown) s_nxt.ots_l = 1'b1;
    // Per-channel events
    for (int c = 0; c < NCH; c++) begin
      if (cycle_current_limit[c]) begin
        if (s_r.oc_cnt[c] == CW'(OC_CYCLES)) begin
          s_nxt.oc_l[c] = 1'b1;
        end else begin
          s_nxt.oc_cnt[c] = s_r.oc_cnt[c] + CW'(1);
        end
      end else begin
        s_nxt.oc_cnt[c] = '0;
      end
      if (dc_det[c]) s_nxt.dc_l[c] = 1'b1;
      if (diag_fault[c] && s_r.st[c] == 2'(amp_ctrl_pkg::ST_HIZ)) begin
        s_nxt.diag_l[c] = 1'b1;
      end
    end
    glob_stby = por_drop || s_nxt.ots_l;
    glob_hiz  = s_nxt.uv_l || s_nxt.ov_l;
    // Channel state selection
    for (int c = 0; c < NCH; c++) begin
      if (glob_stby) begin
        s_nxt.st[c] = 2'(amp_ctrl_pkg::ST_STANDBY);
      end else if (glob_hiz || s_nxt.oc_l[c] || s_nxt.dc_l[c] || !s_nxt.unhiz[c]) begin
        s_nxt.st[c] = 2'(amp_ctrl_pkg::ST_HIZ);
      end else if (mute_s || !s_nxt.play[c]) begin
        s_nxt.st[c] = 2'(amp_ctrl_pkg::ST_MUTE);
      end else begin
        s_nxt.st[c] = 2'(amp_ctrl_pkg::ST_PLAY);
      end
    end
    // Fault pin: any automatic Hi-Z or standby cause
    s_nxt.fault_n = ~(glob_stby || glob_hiz || (|s_nxt.oc_l) || (|s_nxt.dc_l));
    // Clip/warning pin selection
    case (s_r.cwsel)
      `CWSEL_TWEETER: cw_any = 1'b0;
      `CWSEL_CLIP:    cw_any = |clip_det;
      `CWSEL_OTW:     cw_any = overtemp_warning;
      default:        cw_any = overtemp_warning || (|clip_det);
    endcase
    if (s_r.fold_rep && (|foldback)) cw_any = 1'b1;
    if (tweeter_diag_run && tweeter_found) cw_any = 1'b1;
    s_nxt.clip_n = ~cw_any;
    // Standby pin wipes host registers and latches
    if (stby_s) begin
      s_nxt       = '0;
      s_nxt.fsw   = `FSW_RST;
      s_nxt.cwsel = `CWSEL_RST;
      s_nxt.wide  = `PHASE_RST;
      s_nxt.clip_n  = 1'b1;
      s_nxt.fault_n = ~por_drop;
      s_nxt.por_l   = por_drop;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r         <= '0;
      s_r.fsw     <= `FSW_RST;
      s_r.cwsel   <= `CWSEL_RST;
      s_r.fault_n <= 1'b1;
      s_r.clip_n  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign fault_n_out     = 1'b0;
  assign fault_n_oe      = ~s_r.fault_n;
  assign clip_warn_n_out = s_r.clip_n;
  assign host_link_en    = ~stby_s && ~s_r.por_l;
  assign fsw_sel         = dec_fsw(s_r.fsw);
  assign fsw_invalid     = (s_r.fsw == `FSW_INVALID);
  assign phase_deg       = s_r.wide ? `PHASE_WIDE : `PHASE_NARROW;
  assign fault_status    = {2'h0, s_r.ots_l, overtemp_warning, s_r.ov_l, s_r.uv_l,
                            |s_r.oc_l, |s_r.dc_l};
  assign ch_oc_status    = s_r.oc_l;
  assign ch_dc_status    = s_r.dc_l;
  assign ch_diag_status  = s_r.diag_l;
  assign ch_foldback_status = foldback;
  // Hard mute on overcurrent, DC, overtemp shutdown and supply drop; ramp in mute state
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ch_state[c]  = s_r.st[c];
      hard_mute[c] = s_r.oc_l[c] || s_r.dc_l[c] || s_r.ots_l || s_r.por_l;
      ramp_mute[c] = s_r.st[c] == 2'(amp_ctrl_pkg::ST_MUTE);
    end
  end

  // Fault pin driven in the same cycle as a latched shutdown, undervoltage or overvoltage
  property p_fault_pin;
    @(posedge core_clk) disable iff (sys_rst)
      (s_r.ots_l || s_r.uv_l || s_r.ov_l) |-> fault_n_oe;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin not driven");

  property p_ots_standby;
    @(posedge core_clk) disable iff (sys_rst)
      (overtemp_shutdown && !stby_s) |=> (s_r.st[0] == 2'(amp_ctrl_pkg::ST_STANDBY));
  endproperty
  a_ots_standby: assert property (p_ots_standby) else $error("no standby on shutdown");

  property p_uv_latch;
    @(posedge core_clk) disable iff (sys_rst)
      (s_r.uv_l && !host_clear && !stby_s) |=> s_r.uv_l;
  endproperty
  a_uv_latch: assert property (p_uv_latch) else $error("undervoltage not held");

  property p_dc_hiz;
    @(posedge core_clk) disable iff (sys_rst)
      (s_r.dc_l[0] && !s_r.ots_l && !s_r.por_l) |-> s_r.st[0] == 2'(amp_ctrl_pkg::ST_HIZ);
  endproperty
  a_dc_hiz: assert property (p_dc_hiz) else $error("dc fault not in hiz");

  property p_tweeter;
    @(posedge core_clk) disable iff (sys_rst)
      (tweeter_diag_run && tweeter_found && !stby_s) |=> !clip_warn_n_out;
  endproperty
  a_tweeter: assert property (p_tweeter) else $error("tweeter not flagged");

  // A taken write sets the phase offset seen one cycle later
  property p_phase;
    @(posedge core_clk) disable iff (sys_rst)
      (host_wr && mute_ramp_done && !stby_s)
      |=> (phase_deg == ($past(host_phase_wide) ? `PHASE_WIDE : `PHASE_NARROW));
  endproperty
  a_phase: assert property (p_phase) else $error("phase wrong");

  // Mute pin held: neither first nor last channel may be playing in the next cycle
  sequence s_mute_held;
    mute_s && !stby_s;
  endsequence
  property p_mute;
    @(posedge core_clk) disable iff (sys_rst)
      s_mute_held |=> (s_r.st[0] != 2'(amp_ctrl_pkg::ST_PLAY))
                      && (s_r.st[NCH-1] != 2'(amp_ctrl_pkg::ST_PLAY));
  endproperty
  a_mute: assert property (p_mute) else $error("playing while muted");

  property p_standby_clear;
    @(posedge core_clk) disable iff (sys_rst)
      stby_s |-> !host_link_en ##1 (s_r.fsw == `FSW_RST);
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("standby kept state");
endmodule : amp_state_fault_manager
`default_nettype wire

// *** core/pin_sync3.sv ***
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module pin_sync3 #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  // All stages packed in one state
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_st_t;
  sync_st_t st_r;
  sync_st_t st_nxt;

  // Shift, update the clean level only on agreement
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{s1: RST, s2: RST, s3: RST, q: RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.q;
endmodule : pin_sync3
`default_nettype wire

// *** include/amp_ctrl_map.svh ***
`ifndef AMP_CTRL_MAP_SVH
`define AMP_CTRL_MAP_SVH
// Switching frequency field codes
`define FSW_500K        2'h0
`define FSW_357K        2'h2
`define FSW_INVALID     2'h3
// Clip/warning output selection codes
`define CWSEL_TWEETER   2'h0
`define CWSEL_CLIP      2'h1
`define CWSEL_OTW       2'h2
// Phase offsets in degrees
`define PHASE_NARROW    8'h2D
`define PHASE_WIDE      8'hB4
// Reset values of the host settings
`define FSW_RST         2'h1
`define CWSEL_RST       2'h3
`define PHASE_RST       1'b0
// Overcurrent timer length in microseconds, and cycles at 100 MHz
`define OC_TIME_US      10
`define CLK_MHZ         100
`define OC_CYCLES       (`OC_TIME_US * `CLK_MHZ)
`endif

// *** include/amp_ctrl_pkg.sv ***
`default_nettype none
package amp_ctrl_pkg;
  // Output stage states
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_HIZ,
    ST_MUTE,
    ST_PLAY
  } amp_state_t;
  // Switching frequency decoded
  typedef enum logic [1:0] {
    FREQ_500K,
    FREQ_417K,
    FREQ_357K,
    FREQ_BAD
  } freq_t;
endpackage : amp_ctrl_pkg
`default_nettype wire

// *** tb/host_ctrl_model.sv ***
`default_nettype none
// Host side: setting writes and fault clears, driven at the falling edge
module host_ctrl_model (
  input  wire logic       core_clk,
  output logic            host_wr,
  output logic [1:0]      host_fsw,
  output logic [1:0]      host_cwsel,
  output logic            host_phase_wide,
  output logic            host_foldback_rep,
  output logic [1:0]      host_play,
  output logic [1:0]      host_unhiz,
  output logic            host_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero
  initial begin
    host_wr = 1'b0;
    host_clear = 1'b0;
    host_foldback_rep = 1'b0;
    {host_fsw, host_cwsel, host_phase_wide, host_play, host_unhiz} = 9'h000;
  end
  // One write held over one rising edge; data scrambled once released
  task automatic write(input logic [1:0] f, c, input logic w, input logic [1:0] p, u);
    @(negedge core_clk);
    host_wr = 1'b1;
    host_fsw = f;  // Picked per radio band
    host_cwsel = c;
    host_phase_wide = w;
    host_play = p;  // Play low mutes by command
    host_unhiz = u;
    @(negedge core_clk);
    host_wr = 1'b0;
    {host_fsw, host_cwsel, host_phase_wide, host_play, host_unhiz} = ~{f, c, w, p, u};
  endtask : write
  // Foldback report enable, carried by the following write
  task automatic set_fold(input logic r);
    @(negedge core_clk);
    host_foldback_rep = r;
  endtask : set_fold
  // One-cycle clear of latched faults
  task automatic clear();
    @(negedge core_clk);
    host_clear = 1'b1;
    @(negedge core_clk);
    host_clear = 1'b0;
  endtask : clear
endmodule : host_ctrl_model
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
// Bench: driver notes expectations, monitor compares them on each snapshot
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OCN = 8;  // Short overcurrent timer
  logic core_clk, sys_rst, standby_n_in, mute_n_in, por_drop, undervolt, overvolt;
  logic overtemp_warning, overtemp_shutdown, tweeter_diag_run, tweeter_found, hit;
  logic mute_ramp_done, host_wr, host_phase_wide, host_foldback_rep, host_clear;
  logic [1:0] clip_det, cycle_current_limit, dc_det, host_fsw, host_cwsel, host_play;
  logic [1:0] host_unhiz, hard_mute, ramp_mute, ch_oc_status, ch_dc_status;
  logic [1:0] ch_diag_status, ch_foldback_status, foldback, diag_fault;
  logic [1:0] ch_state [2];  // Per-channel state
  logic fault_n_out, fault_n_oe, clip_warn_n_out, host_link_en, fsw_invalid;
  logic [7:0] phase_deg, fault_status;
  amp_ctrl_pkg::freq_t fsw_sel;
  logic [11:0] notes [$];  // Output select and expected value
  logic [11:0] cur;
  int bad_count, check_count, cycles, seed;
  event snap_ev;  // Outputs settled
  event ack_ev;   // Snapshot compared
  // Device under test
  amp_state_fault_manager #(.NCH(2), .OC_CYCLES(OCN)) amp_state_fault_manager_inst (
    .core_clk, .sys_rst, .standby_n_in, .mute_n_in, .por_drop, .undervolt, .overvolt,
    .overtemp_warning, .overtemp_shutdown, .clip_det, .cycle_current_limit, .dc_det,
    .foldback, .diag_fault, .tweeter_diag_run, .tweeter_found, .mute_ramp_done, .host_wr,
    .host_fsw, .host_cwsel, .host_phase_wide, .host_foldback_rep, .host_play, .host_unhiz,
    .host_clear, .fault_n_out, .fault_n_oe, .clip_warn_n_out, .host_link_en, .ch_state,
    .hard_mute, .ramp_mute, .fsw_sel, .phase_deg, .fsw_invalid, .fault_status,
    .ch_oc_status, .ch_dc_status, .ch_diag_status, .ch_foldback_status
  );
  // Host model
  host_ctrl_model host_ctrl_model_inst (
    .core_clk, .host_wr, .host_fsw, .host_cwsel, .host_phase_wide, .host_foldback_rep,
    .host_play, .host_unhiz, .host_clear
  );
  // Clock, 10 ns
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Output picked by select code
  function automatic logic [7:0] obs(input logic [3:0] s);
    case (s)
      4'h0: obs = {6'h00, fsw_sel};
      4'h1: obs = {7'h00, fsw_invalid};
      4'h2: obs = phase_deg;
      4'h3: obs = {7'h00, clip_warn_n_out};
      4'h4: obs = {7'h00, fault_n_oe};
      4'h5: obs = {7'h00, host_link_en};
      4'h6: obs = {6'h00, ch_state[0]};
      4'h7: obs = {6'h00, ch_state[1]};
      4'h8: obs = fault_status;
      4'h9: obs = {6'h00, ch_oc_status};
      4'hA: obs = {6'h00, ch_dc_status};
      4'hB: obs = {6'h00, hard_mute};
      4'hC: obs = {6'h00, ramp_mute};
      4'hD: obs = {6'h00, ch_diag_status};
      4'hE: obs = {6'h00, ch_foldback_status};
      default: obs = {7'h00, fault_n_out};
    endcase
  endfunction : obs
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Queue an expectation
  task automatic nt(input logic [3:0] s, input logic [7:0] e);
    notes.push_back({s, e});
  endtask : nt
  // Wait n falling edges, take a snapshot, hold inputs until compared
  task automatic look(input int n);
    repeat (n) @(negedge core_clk);
    -> snap_ev;
    @(ack_ev);
  endtask : look
  // Shorthands for host writes
  task automatic wr(input logic [1:0] f, c, input logic w, input logic [1:0] p, u);
    host_ctrl_model_inst.write(f, c, w, p, u);
  endtask : wr
  task automatic play();
    wr(2'h0, 2'h3, 1'b0, 2'h3, 2'h3);
  endtask : play
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  // Counts and verdict
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // Monitor: every queued note, oldest first, against the output it names
  initial begin
    forever begin
      @(snap_ev);
      while (notes.size() > 0) begin
        cur = notes.pop_front();
        check(obs(cur[11:8]), cur[7:0]);
      end
      -> ack_ev;
    end
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    seed = 69537;
    {sys_rst, standby_n_in, mute_n_in, mute_ramp_done} = 4'hF;
    {por_drop, undervolt, overvolt, overtemp_warning, overtemp_shutdown} = 5'h00;
    {clip_det, cycle_current_limit, dc_det, foldback, diag_fault} = 10'h000;
    {tweeter_diag_run, tweeter_found} = 2'h0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    nt(4'h0, 8'h01);
    nt(4'h2, 8'h2D);
    nt(4'h3, 8'h01);
    nt(4'h4, 8'h00);
    nt(4'hF, 8'h00);
    look(6);
    done("reset");
    for (int i = 3; i >= 0; i--) begin
      wr(i[1:0], 2'h3, i[0], 2'h3, 2'h3);
      if (i < 3) nt(4'h0, 8'(i));
      nt(4'h1, {7'h00, i == 3});
      nt(4'h2, i[0] ? 8'hB4 : 8'h2D);
      nt(4'h6, 8'h03);
      look(1);
    end
    mute_ramp_done = 1'b0;
    wr(2'h2, 2'h3, 1'b1, 2'h3, 2'h3);
    nt(4'h0, 8'h00);
    nt(4'h2, 8'h2D);
    look(1);
    mute_ramp_done = 1'b1;
    done("setting decode");
    for (int k = 0; k < 16; k++) begin
      wr(2'h0, k[3:2], 1'b0, 2'h3, 2'h3);
      clip_det = {2{k[1]}};
      overtemp_warning = k[0];
      tweeter_diag_run = 1'b1;
      tweeter_found = 1'($random(seed));
      hit = (k[3:2] == 2'h1 && k[1]) || (k[3:2] == 2'h2 && k[0]);
      hit = hit || (k[3:2] == 2'h3 && k[1:0] != 2'h0) || tweeter_found;
      nt(4'h3, {7'h00, ~hit});
      nt(4'h8, {3'h0, k[0], 4'h0});
      look(3);
    end
    {clip_det, overtemp_warning, tweeter_diag_run, tweeter_found} = 5'h00;
    host_ctrl_model_inst.set_fold(1'b1);
    wr(2'h0, 2'h1, 1'b0, 2'h3, 2'h3);
    foldback = 2'h2;
    nt(4'h3, 8'h00);
    nt(4'hE, 8'h02);
    look(2);
    host_ctrl_model_inst.set_fold(1'b0);
    wr(2'h0, 2'h1, 1'b0, 2'h3, 2'h3);
    nt(4'h3, 8'h01);
    nt(4'hE, 8'h02);
    look(2);
    foldback = 2'h0;
    done("clip and warning");
    for (int f = 0; f < 3; f++) begin
      play();
      undervolt = (f == 0);
      overvolt = (f == 1);
      overtemp_shutdown = (f == 2);
      @(negedge core_clk);
      {undervolt, overvolt, overtemp_shutdown} = 3'h0;
      nt(4'h4, 8'h01);
      nt(4'h6, (f == 2) ? 8'h00 : 8'h01);
      nt(4'h8, 8'h04 << (f + (f == 2)));
      nt(4'hB, (f == 2) ? 8'h03 : 8'h00);
      look(4);
      host_ctrl_model_inst.clear();
      nt(4'h4, 8'h00);
      nt(4'h8, 8'h00);
      look(2);
    end
    done("global faults");
    play();
    cycle_current_limit = 2'h1;
    repeat (OCN) @(negedge core_clk);
    cycle_current_limit = 2'h2;
    nt(4'h9, 8'h00);
    nt(4'h6, 8'h03);
    look(0);
    repeat (OCN + 3) @(negedge core_clk);
    cycle_current_limit = 2'h0;
    dc_det = 2'h1;
    @(negedge core_clk);
    dc_det = 2'h0;
    nt(4'h9, 8'h02);
    nt(4'hA, 8'h01);
    nt(4'h7, 8'h01);
    nt(4'h6, 8'h01);
    nt(4'h4, 8'h01);
    nt(4'h8, 8'h03);
    nt(4'hB, 8'h03);
    look(3);
    host_ctrl_model_inst.clear();
    nt(4'h9, 8'h00);
    nt(4'hA, 8'h00);
    look(2);
    diag_fault = 2'h3;
    @(negedge core_clk);
    nt(4'hD, 8'h00);
    look(0);
    wr(2'h0, 2'h3, 1'b0, 2'h3, 2'h1);
    nt(4'hD, 8'h02);
    look(1);
    diag_fault = 2'h0;
    done("channel faults");
    play();
    por_drop = 1'b1;
    nt(4'h5, 8'h00);
    nt(4'h4, 8'h01);
    nt(4'h6, 8'h00);
    nt(4'hB, 8'h03);
    look(2);
    por_drop = 1'b0;
    nt(4'h4, 8'h00);
    look(3);
    done("supply drop");
    play();
    mute_n_in = 1'b0;
    nt(4'h6, 8'h02);
    nt(4'h7, 8'h02);
    nt(4'hC, 8'h03);
    look(8);
    mute_n_in = 1'b1;
    repeat (8) @(negedge core_clk);
    wr(2'h0, 2'h3, 1'b0, 2'h0, 2'h3);
    nt(4'h6, 8'h02);
    nt(4'h7, 8'h02);
    look(1);
    done("mute");
    wr(2'h2, 2'h3, 1'b1, 2'h3, 2'h3);
    standby_n_in = 1'b0;
    nt(4'h5, 8'h00);
    nt(4'h6, 8'h00);
    look(8);
    standby_n_in = 1'b1;
    nt(4'h0, 8'h01);
    nt(4'h2, 8'h2D);
    nt(4'hD, 8'h00);
    look(8);
    done("standby");
    look(1);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
